// file: shared/lpc_pkg.sv
// constants and types shared by the loopback control block
package lpc_pkg;

	// clock and persistence timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned PERSIST_MS = 5100;
	localparam int unsigned PERSIST_CYCLES = PERSIST_MS * (CLK_HZ / 1000);
	localparam int unsigned PERSIST_CNT_W = 26;

	// reset values of the control state
	localparam logic RST_BIT = 1'b0;
	localparam logic [PERSIST_CNT_W-1:0] RST_COUNT = 26'h0000000;

	// line value sent while alarm indication is generated
	localparam logic AIS_BIT = 1'b1;

	// automatic loopback states, one-hot
	typedef enum logic [2:0] {
		LPC_AUTO_IDLE = 3'h1,
		LPC_AUTO_REMOTE = 3'h2,
		LPC_AUTO_DIGITAL = 3'h4
	} lpc_auto_t;

endpackage

// file: shared/lpc_path_if.sv
// per-path steering signals between loopback control and path selector
`timescale 1ns/1ns
interface lpc_path_if;
	logic native_bit;
	logic looped_bit;
	logic pattern_bit;
	logic use_loop;
	logic loop_first;
	logic pattern_en;
	logic ais_en;
	logic out_bit;

	// control side drives choices, selector returns the path bit
	modport ctrl (
		output native_bit, looped_bit, pattern_bit,
		output use_loop, loop_first, pattern_en, ais_en,
		input out_bit
	);
	modport sel (
		input native_bit, looped_bit, pattern_bit,
		input use_loop, loop_first, pattern_en, ais_en,
		output out_bit
	);
endinterface

// file: core/lpc_persist_timer.sv
// persistence timer: flags a level held for the full limit
`timescale 1ns/1ns
module lpc_persist_timer
	import lpc_pkg::*;
#(
	parameter int unsigned LIMIT = PERSIST_CYCLES
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// level being timed and its result
	input wire logic watch,
	output logic held
);
	typedef struct packed {
		logic [PERSIST_CNT_W-1:0] count;
	} lpc_tmr_state_t;

	lpc_tmr_state_t state_reg;
	lpc_tmr_state_t state_next;

	initial
	begin
		if (LIMIT < 1 || LIMIT >= (64'h1 << PERSIST_CNT_W))
			$error("persistence limit out of counter range");
	end

	// count up while the level stands, restart on any gap
	always_comb
	begin
		state_next = state_reg;
		if (!watch)
			state_next.count = RST_COUNT;
		else if (state_reg.count != LIMIT[PERSIST_CNT_W-1:0])
			state_next.count = state_reg.count + 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			state_reg <= '{count: RST_COUNT};
		else
			state_reg <= state_next;
	end

	// held once LIMIT cycles of continuous level have passed
	assign held = watch && state_reg.count == LIMIT[PERSIST_CNT_W-1:0];
endmodule

// file: core/lpc_path_select.sv
// one data path selector: pattern, looped data, alarm fill, native data
`timescale 1ns/1ns
module lpc_path_select
	import lpc_pkg::*;
(
	// clock, reset and line bit strobe
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic line_bit_en,
	// steering from the control side
	lpc_path_if.sel path
);
	typedef struct packed {
		logic out_bit;
	} lpc_sel_state_t;

	lpc_sel_state_t state_reg;
	lpc_sel_state_t state_next;

	// priority chain, evaluated once per line bit
	always_comb
	begin
		state_next = state_reg;
		if (line_bit_en)
		begin
			if (path.use_loop && path.loop_first)
				state_next.out_bit = path.looped_bit;
			else if (path.pattern_en)
				state_next.out_bit = path.pattern_bit;
			else if (path.use_loop)
				state_next.out_bit = path.looped_bit;
			else if (path.ais_en)
				state_next.out_bit = AIS_BIT;
			else
				state_next.out_bit = path.native_bit;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			state_reg <= '{out_bit: RST_BIT};
		else
			state_reg <= state_next;
	end

	assign path.out_bit = state_reg.out_bit;
endmodule

// file: core/lpc_loopback_ctrl.sv
// loopback selection and data steering for one line channel
//
// Behaviour
// - analog loop feeds transmit data into receive
// - analog loop forces remote and digital off
// - analog: receive pattern wins; no alarm fill
// - remote active on manual or automatic request
// - receive code held 5.1 s toggles remote
// - clearing auto enable ends automatic remote
// - auto loop state shows automatic loop active
// - remote: received data goes back to line
// - transmit detectors still watch system data
// - remote: pattern priorities, no transmit alarm fill
// - digital active on manual or automatic request
// - transmit code held 5.1 s toggles digital
// - digital: transmit data replaces received data
// - digital: path priorities, no receive alarm fill
// - dual only with manual remote loop
// - dual: both loops, detectors placed accordingly
// - manual dual: remote data beats transmit pattern
// - manual remote plus auto digital: no transmit pattern
`timescale 1ns/1ns
module lpc_loopback_ctrl
	import lpc_pkg::*;
#(
	parameter int unsigned PERSIST_LIMIT = PERSIST_CYCLES
)(
	// clock, reset and line bit strobe
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic line_bit_en,
	// loopback control bits
	input wire logic analog_loop_bit,
	input wire logic manual_remote_loop_bit,
	input wire logic manual_digital_loop_bit,
	input wire logic auto_loop_enable,
	input wire logic pattern_detect_side,
	// inband loop code detector levels
	input wire logic inband_act_rx,
	input wire logic inband_deact_rx,
	input wire logic inband_act_tx,
	input wire logic inband_deact_tx,
	// line side data
	input wire logic rx_line_data,
	input wire logic tx_line_data,
	// system side data and clock state
	input wire logic tx_sys_data,
	input wire logic tx_sys_clk_lost,
	// diagnostic generators
	input wire logic rx_pattern_gen_en,
	input wire logic rx_pattern_bit,
	input wire logic rx_ais_gen_en,
	input wire logic tx_pattern_gen_en,
	input wire logic tx_pattern_bit,
	input wire logic tx_ais_gen_en,
	// steered data
	output logic rx_dec_data,
	output logic tx_shaper_data,
	// detector feeds
	output logic rx_det_data,
	output logic rx_los_ais_data,
	output logic tx_det_data,
	output logic pd_data,
	output logic tx_clk_lost_eff,
	// status
	output logic analog_active,
	output logic remote_active,
	output logic digital_active,
	output logic auto_loop_state
);
	// one register image for the sequencer, status and detector feeds; the sequencer is
	// kept apart from the effective loops, so analog only masks it
	typedef struct packed {
		// automatic loop sequencer
		lpc_auto_t auto_st;
		// status copies of the effective loops and of the sequencer state
		logic analog;
		logic remote;
		logic digital;
		logic auto_on;
		// detector feeds and masked clock loss
		logic rx_det;
		logic rx_los;
		logic tx_det;
		logic pd;
		logic clk_lost;
	} lpc_ctrl_state_t;

	lpc_ctrl_state_t state_reg;
	lpc_ctrl_state_t state_next;

	lpc_path_if rx_path();
	lpc_path_if tx_path();

	// code timing
	logic act_watch;
	logic deact_watch;
	logic act_held;
	logic deact_held;

	// decoded loop modes
	logic auto_remote;
	logic auto_digital;
	logic remote_eff;
	logic digital_eff;
	logic dual_auto_dig;

	initial
	begin
		if (PERSIST_LIMIT < 1)
			$error("persistence limit must be at least one cycle");
		// the timers count in a fixed width counter
		if (PERSIST_LIMIT >= (64'h1 << PERSIST_CNT_W))
			$error("persistence limit exceeds timer width");
	end

	// automatic loop flags straight from the state
	assign auto_remote = state_reg.auto_st == LPC_AUTO_REMOTE;
	assign auto_digital = state_reg.auto_st == LPC_AUTO_DIGITAL;

	// effective loops; analog overrides the others
	assign remote_eff = !analog_loop_bit
		&& (manual_remote_loop_bit || auto_remote);
	assign digital_eff = !analog_loop_bit
		&& (manual_digital_loop_bit || auto_digital);
	assign dual_auto_dig = remote_eff && auto_digital;

	// inband codes are taken from the path the detector sits in
	assign act_watch = auto_loop_enable
		&& state_reg.auto_st == LPC_AUTO_IDLE
		&& (pattern_detect_side ? inband_act_tx : inband_act_rx);
	assign deact_watch = auto_loop_enable
		&& state_reg.auto_st != LPC_AUTO_IDLE
		&& (pattern_detect_side ? inband_deact_tx : inband_deact_rx);

	// activate and deactivate codes timed separately; a single
	// timer would let a deactivate code inherit activate credit
	// and end a fresh loop early
	lpc_persist_timer #(
		.LIMIT(PERSIST_LIMIT)
	) u_act_timer (
		.sys_clk(sys_clk),
		.srst(srst),
		.watch(act_watch),
		.held(act_held)
	);

	lpc_persist_timer #(
		.LIMIT(PERSIST_LIMIT)
	) u_deact_timer (
		.sys_clk(sys_clk),
		.srst(srst),
		.watch(deact_watch),
		.held(deact_held)
	);

	// receive path: looped transmit data under analog or digital loop
	// receive pattern always beats looped data, so no loop_first here
	assign rx_path.native_bit = rx_line_data;
	assign rx_path.looped_bit = tx_line_data;
	assign rx_path.pattern_bit = rx_pattern_bit;
	assign rx_path.use_loop = analog_loop_bit || digital_eff;
	assign rx_path.loop_first = 1'b0;
	assign rx_path.pattern_en = rx_pattern_gen_en;
	// alarm fill only in normal or remote loop
	assign rx_path.ais_en = rx_ais_gen_en && !analog_loop_bit
		&& !digital_eff;

	// transmit path: received data sent back under remote loop
	// system data is still steered here, overridden by the loop, pattern or alarm fill
	assign tx_path.native_bit = tx_sys_data;
	assign tx_path.looped_bit = rx_line_data;
	assign tx_path.pattern_bit = tx_pattern_bit;
	assign tx_path.use_loop = remote_eff;
	assign tx_path.loop_first = remote_eff && digital_eff;
	// pattern is lost when remote wraps an automatic digital loop
	assign tx_path.pattern_en = tx_pattern_gen_en && !dual_auto_dig;
	assign tx_path.ais_en = tx_ais_gen_en && !analog_loop_bit
		&& !remote_eff;

	lpc_path_select u_rx_sel (
		.sys_clk(sys_clk),
		.srst(srst),
		.line_bit_en(line_bit_en),
		.path(rx_path)
	);

	lpc_path_select u_tx_sel (
		.sys_clk(sys_clk),
		.srst(srst),
		.line_bit_en(line_bit_en),
		.path(tx_path)
	);

	// automatic loop sequencing and detector steering
	always_comb
	begin
		state_next = state_reg;
		case (state_reg.auto_st)
			LPC_AUTO_IDLE:
			begin
				// remote needs the receive side and no digital loop
				if (act_held && !pattern_detect_side && !digital_eff)
					state_next.auto_st = LPC_AUTO_REMOTE;
				else if (act_held && pattern_detect_side)
					state_next.auto_st = LPC_AUTO_DIGITAL;
			end

			// automatic remote runs until code, enable or manual digital
			LPC_AUTO_REMOTE:
			begin
				// a manual digital loop also takes the remote away
				if (!auto_loop_enable || deact_held
					|| manual_digital_loop_bit)
					state_next.auto_st = LPC_AUTO_IDLE;
			end

			// automatic digital may sit under a manual remote loop
			LPC_AUTO_DIGITAL:
			begin
				if (!auto_loop_enable || deact_held)
					state_next.auto_st = LPC_AUTO_IDLE;
			end

			// an illegal code falls back to no automatic loop
			default:
				state_next.auto_st = LPC_AUTO_IDLE;
		endcase

		// status follows the loops one cycle late
		state_next.analog = analog_loop_bit;
		state_next.remote = remote_eff;
		state_next.digital = digital_eff;
		state_next.auto_on = state_reg.auto_st != LPC_AUTO_IDLE;
		// clock loss is of no concern while the line is fed back
		state_next.clk_lost = tx_sys_clk_lost && !remote_eff;

		// detector feeds move once per line bit
		if (line_bit_en)
		begin
			// violation and zeroes detectors follow the receive loop
			state_next.rx_det = rx_path.use_loop ? tx_line_data
				: rx_line_data;
			// line alarms keep watching the line except in analog loop
			state_next.rx_los = analog_loop_bit ? tx_line_data
				: rx_line_data;
			// transmit detectors never see looped data
			state_next.tx_det = tx_sys_data;

			// pattern detector sits on the chosen side: receive side after any loop, transmit side on system data
			state_next.pd = pattern_detect_side ? tx_sys_data
				: (rx_path.use_loop ? tx_line_data : rx_line_data);
		end
	end

	// every field named in reset so none starts unknown
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_reg.auto_st <= LPC_AUTO_IDLE;
			state_reg.analog <= RST_BIT;
			state_reg.remote <= RST_BIT;
			state_reg.digital <= RST_BIT;
			state_reg.auto_on <= RST_BIT;
			state_reg.rx_det <= RST_BIT;
			state_reg.rx_los <= RST_BIT;
			state_reg.tx_det <= RST_BIT;
			state_reg.pd <= RST_BIT;
			state_reg.clk_lost <= RST_BIT;
		end
		else
			state_reg <= state_next;
	end

	// steered data, registered in the selectors
	assign rx_dec_data = rx_path.out_bit;
	assign tx_shaper_data = tx_path.out_bit;

	// detector feeds, all from flip-flops
	assign rx_det_data = state_reg.rx_det;
	assign rx_los_ais_data = state_reg.rx_los;
	assign tx_det_data = state_reg.tx_det;
	assign pd_data = state_reg.pd;
	assign tx_clk_lost_eff = state_reg.clk_lost;

	// status, one cycle behind the controls
	assign analog_active = state_reg.analog;
	assign remote_active = state_reg.remote;
	assign digital_active = state_reg.digital;
	assign auto_loop_state = state_reg.auto_on;
endmodule

// file: tb/lpc_far_model.sv
// far side model: line bit strobe plus line and system data
`timescale 1ns/1ns
module lpc_far_model (
	// clock
	input wire logic sys_clk,
	// strobe and data toward the block
	output logic line_bit_en,
	output logic rx_line_data,
	output logic tx_line_data,
	output logic tx_sys_data
);
	logic [1:0] div_reg = 2'h0;
	logic [2:0] bit_reg = 3'h0;
	// one bit every third clock; data walks all eight mixes
	always_ff @(posedge sys_clk)
	begin
		div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
		if (div_reg == 2'h2)
			bit_reg <= bit_reg + 3'h1;
	end
	// distinct streams so a wrong steering choice shows
	assign line_bit_en = (div_reg == 2'h2);
	assign {tx_sys_data, tx_line_data, rx_line_data} = bit_reg;
endmodule

// file: tb/lpc_loopback_asserts.sv
// checker of loopback steering, bound to the loopback control module
`timescale 1ns/1ns
module lpc_loopback_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// inputs
	input wire logic line_bit_en,
	input wire logic analog_loop_bit,
	input wire logic manual_remote_loop_bit,
	input wire logic manual_digital_loop_bit,
	input wire logic auto_loop_enable,
	input wire logic rx_line_data,
	input wire logic tx_sys_data,
	input wire logic rx_pattern_gen_en,
	input wire logic rx_pattern_bit,
	input wire logic tx_pattern_gen_en,
	// outputs
	input wire logic rx_dec_data,
	input wire logic tx_shaper_data,
	input wire logic tx_det_data,
	input wire logic analog_active,
	input wire logic remote_active,
	input wire logic digital_active,
	input wire logic auto_loop_state
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// enable low over three edges: state drops, then status follows
	sequence auto_off_s;
		!auto_loop_enable ##1 !auto_loop_enable ##1 !auto_loop_enable;
	endsequence
	AST_ANA_MASK: assert property (
		analog_active |-> !remote_active && !digital_active)
		else $error("loop left on in analog loop");
	AST_ANA_ON: assert property (
		analog_loop_bit |=> analog_active)
		else $error("analog loop not active");
	AST_REM_ON: assert property (
		manual_remote_loop_bit && !analog_loop_bit |=> remote_active)
		else $error("manual remote not active");
	AST_DIG_ON: assert property (
		manual_digital_loop_bit && !analog_loop_bit |=> digital_active)
		else $error("manual digital not active");
	AST_AUTO_OFF: assert property (
		auto_off_s |=> !auto_loop_state)
		else $error("auto loop kept without enable");
	AST_TX_DET: assert property (
		line_bit_en |=> tx_det_data == $past(tx_sys_data))
		else $error("transmit detectors lost system data");
	AST_RX_PAT: assert property (
		line_bit_en && rx_pattern_gen_en
		|=> rx_dec_data == $past(rx_pattern_bit))
		else $error("receive pattern did not win");
	AST_REM_LOOP: assert property (
		line_bit_en && remote_active && manual_remote_loop_bit
		&& !tx_pattern_gen_en |=> tx_shaper_data == $past(rx_line_data))
		else $error("received data not looped to line");
endmodule
bind lpc_loopback_ctrl lpc_loopback_asserts chk_i (.sys_clk, .srst,
	.line_bit_en, .analog_loop_bit, .manual_remote_loop_bit,
	.manual_digital_loop_bit, .auto_loop_enable, .rx_line_data,
	.tx_sys_data, .rx_pattern_gen_en, .rx_pattern_bit, .tx_pattern_gen_en,
	.rx_dec_data, .tx_shaper_data, .tx_det_data, .analog_active,
	.remote_active, .digital_active, .auto_loop_state);

// file: tb/lpc_loopback_ctrl_test.sv
// testbench for the loopback control block
`timescale 1ns/1ns
module lpc_loopback_ctrl_test import lpc_pkg::*;;
	localparam int unsigned LIM = 20;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_lost = 1'b1;
	logic [4:0] ctl = 5'h00; // analog remote digital auto side
	logic [5:0] gen = 6'h00; // rx pat en/bit ais, tx pat en/bit ais
	logic [3:0] ib = 4'h0; // act rx, deact rx, act tx, deact tx
	logic line_bit_en, rx_line_data, tx_line_data, tx_sys_data;
	logic rx_dec_data, tx_shaper_data, rx_det_data, rx_los_ais_data;
	logic tx_det_data, pd_data, tx_clk_lost_eff, analog_active;
	logic remote_active, digital_active, auto_loop_state;
	logic r, t, s;
	int fails = 0;
	int check_count = 0;
	// block and far side
	lpc_loopback_ctrl #(.PERSIST_LIMIT(LIM)) uut (.sys_clk, .srst,
		.line_bit_en, .analog_loop_bit(ctl[4]),
		.manual_remote_loop_bit(ctl[3]), .manual_digital_loop_bit(ctl[2]),
		.auto_loop_enable(ctl[1]), .pattern_detect_side(ctl[0]),
		.inband_act_rx(ib[3]), .inband_deact_rx(ib[2]),
		.inband_act_tx(ib[1]), .inband_deact_tx(ib[0]),
		.rx_line_data, .tx_line_data, .tx_sys_data,
		.tx_sys_clk_lost(clk_lost), .rx_pattern_gen_en(gen[5]),
		.rx_pattern_bit(gen[4]), .rx_ais_gen_en(gen[3]),
		.tx_pattern_gen_en(gen[2]), .tx_pattern_bit(gen[1]),
		.tx_ais_gen_en(gen[0]), .rx_dec_data, .tx_shaper_data, .rx_det_data,
		.rx_los_ais_data, .tx_det_data, .pd_data, .tx_clk_lost_eff,
		.analog_active, .remote_active, .digital_active, .auto_loop_state);
	lpc_far_model far_i (.sys_clk, .line_bit_en, .rx_line_data,
		.tx_line_data, .tx_sys_data);
	// 100 ns period
	initial
	begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic e, input logic v);
		check_count++;
		if (v !== e)
		begin
			fails++;
			$display("BAD %s exp %b got %b", n, e, v);
		end
	endtask
	// controls change on an edge, then let status settle
	task automatic drive(input logic [4:0] c, input logic [5:0] g);
		@(posedge sys_clk);
		ctl <= c;
		gen <= g;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic code(input logic [3:0] c, input int n);
		@(posedge sys_clk);
		ib <= c;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// capture what the block takes on a strobe edge, bounded wait
	task automatic smp;
		int n;
		n = 0;
		while (line_bit_en !== 1'b1 && n < 9)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		r = rx_line_data;
		t = tx_line_data;
		s = tx_sys_data;
		@(posedge sys_clk);
		#1;
		if (n >= 9)
		begin
			fails++;
			close_out();
		end
	endtask
	task automatic t_normal;
		drive(5'h00, 6'h08);
		repeat (4)
		begin
			smp();
			chk("rx_ais", AIS_BIT, rx_dec_data);
			chk("rx_det", r, rx_det_data);
			chk("pd_rx", r, pd_data);
			chk("clk_lost", 1'b1, tx_clk_lost_eff);
		end
	endtask
	task automatic t_analog;
		drive(5'h1C, 6'h09);
		chk("ana_mask", 1'b0, remote_active | digital_active);
		repeat (4)
		begin
			smp();
			chk("ana_rx", t, rx_dec_data);
			chk("ana_tx", s, tx_shaper_data);
		end
	endtask
	task automatic t_remote;
		drive(5'h08, 6'h01);
		repeat (4)
		begin
			smp();
			chk("rem_tx", r, tx_shaper_data);
			chk("rem_rx", r, rx_dec_data);
			chk("rem_det", s, tx_det_data);
			chk("rem_clk", 1'b0, tx_clk_lost_eff);
		end
		drive(5'h08, 6'h0C);
		repeat (4)
		begin
			smp();
			chk("rem_ais", AIS_BIT, rx_dec_data);
			chk("rem_pat", 1'b0, tx_shaper_data);
		end
	endtask
	task automatic t_digital;
		drive(5'h04, 6'h0C);
		repeat (4)
		begin
			smp();
			chk("dig_rx", t, rx_dec_data);
			chk("dig_los", r, rx_los_ais_data);
			chk("dig_pat", 1'b0, tx_shaper_data);
		end
	endtask
	task automatic t_dual;
		drive(5'h0C, 6'h04);
		repeat (4)
		begin
			smp();
			chk("dual_tx", r, tx_shaper_data);
			chk("dual_rx", t, rx_dec_data);
			chk("dual_det", t, rx_det_data);
			chk("dual_tdet", s, tx_det_data);
		end
	endtask
	// side bit held fixed while an auto loop runs
	task automatic t_auto;
		drive(5'h02, 6'h00);
		code(4'h8, LIM - 4);
		chk("auto_early", 1'b0, auto_loop_state);
		code(4'h8, 12);
		chk("auto_rem", 1'b1, remote_active & auto_loop_state);
		code(4'h4, LIM + 12);
		chk("auto_exit", 1'b0, remote_active | auto_loop_state);
		code(4'h8, LIM + 12);
		drive(5'h00, 6'h00);
		chk("auto_clr", 1'b0, remote_active | auto_loop_state);
		drive(5'h06, 6'h00);
		code(4'h8, LIM + 12);
		chk("auto_refuse", 1'b0, remote_active);
		drive(5'h0B, 6'h04);
		code(4'h2, LIM + 12);
		chk("auto_dig", 1'b1, digital_active & auto_loop_state);
		repeat (4)
		begin
			smp();
			chk("dual_auto_tx", r, tx_shaper_data);
			chk("dual_auto_rx", t, rx_dec_data);
		end
		code(4'h1, LIM + 12);
		chk("auto_dig_exit", 1'b0, digital_active | auto_loop_state);
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge sys_clk);
		#1;
		chk("reset_out", 1'b0, analog_active | remote_active);
		chk("reset_st", 1'b0, digital_active | auto_loop_state);
		@(posedge sys_clk);
		srst <= 1'b0;
		t_normal();
		t_analog();
		t_remote();
		t_digital();
		t_dual();
		t_auto();
		close_out();
	end
endmodule
